/* bench/dspsp_dsp_model.sv */
// Behavioural DSP serial port facing the port under test
`timescale 1ns/1ps
// ====
// DSP model
module dspsp_dsp_model (
    input wire logic i_sclk, // Bit clock from the port
    input wire logic i_tx_fs, // Frame sync from the port
    input wire logic i_txd, // Data from the port
    input wire logic i_send, // Rising edge starts one frame
    output logic o_rx_fs, // Frame sync to the port
    output logic o_rxd // Data to the port
);
    logic [15:0] got[$];
    logic [15:0] sh = 16'h0000;
    logic [15:0] w;
    logic busy = 1'b0;
    int nb = -1;
    initial o_rx_fs = 1'b0;
    initial o_rxd = 1'b0;
    // No clock of its own, all timing from the port
    always @(negedge i_sclk) begin
        if (nb >= 0) begin
            sh = {sh[14:0], i_txd};
            nb++;
            if (nb % 16 == 0) got.push_back(sh);
            if (nb == 832) nb = -1;
        end else if (i_tx_fs === 1'b1) begin
            nb = 0;
        end
    end
    // Idle data keeps moving so a stale bit cannot pass
    always @(posedge i_sclk) if (!busy) #1 o_rxd = ~o_rxd;
    always begin
        @(posedge i_send);
        busy = 1'b1;
        @(posedge i_sclk) #1 o_rx_fs = 1'b0; // Low phase seen first
        @(posedge i_sclk) #1 o_rx_fs = 1'b1;
        for (int n = 0; n < 1344; n++) begin
            w = 16'hC350 + 16'(n / 16) * 16'h0101;
            @(posedge i_sclk) #1 o_rx_fs = 1'b0;
            o_rxd = w[15 - n % 16];
        end
        @(posedge i_sclk) busy = 1'b0;
    end
endmodule

/* bench/tb_dspsp_top.sv */
// Self-checking bench for the DSP serial port
`timescale 1ns/1ps
// ====
// Bench
module tb_dspsp_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic present = 1'b0;
    logic tx_valid = 1'b0;
    logic [15:0] tx_word = 16'h0000;
    logic send = 1'b0;
    logic tx_ready, underrun, sclk, tx_fs, txd, rx_fs, rxd;
    dspsp_pkg::dspsp_rx_word_t rx;
    logic [15:0] rx_q[$];
    int n_mismatch = 0;
    int comparisons = 0;
    int n_under = 0;
    int n_last = 0;
    int fs_run = 0;
    int fs_len = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    dspsp_top u_dspsp_top (.i_core_clk(clk), .i_arst_n(arst_n), .i_dsp_present(present),
        .i_tx_valid(tx_valid), .i_tx_word(tx_word), .o_tx_ready(tx_ready),
        .o_tx_underrun(underrun), .o_serial_bit_clock(sclk), .o_tx_frame_sync(tx_fs),
        .o_tx_serial_data(txd), .i_rx_frame_sync(rx_fs), .i_rx_serial_data(rxd), .o_rx(rx));
    dspsp_dsp_model u_dspsp_dsp_model (.i_sclk(sclk), .i_tx_fs(tx_fs), .i_txd(txd),
        .i_send(send), .o_rx_fs(rx_fs), .o_rxd(rxd));
    // ====
    // Monitors and timeout
    always @(posedge clk) begin
        cyc++;
        if (rx.valid === 1'b1) rx_q.push_back(rx.word);
        if (rx.valid === 1'b1 && rx.last === 1'b1) n_last = rx_q.size();
        if (underrun === 1'b1) n_under++;
        if (tx_fs === 1'b1) fs_run++;
        else if (fs_run != 0) begin
            fs_len = fs_run;
            fs_run = 0;
        end
        if (cyc == 30000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] tx_pat(input int k);
        return 16'h1234 + 16'(k) * 16'h0F1D;
    endfunction
    task automatic push(input logic [15:0] w);
        @(negedge clk);
        while (tx_ready !== 1'b1) @(negedge clk);
        tx_valid = 1'b1;
        tx_word = w;
        @(negedge clk);
        tx_valid = 1'b0;
    endtask
    // ====
    // Scenarios
    task automatic t_absent();
        int bad;
        bad = 0;
        for (int k = 0; k < 8; k++) push(tx_pat(k));
        @(negedge clk);
        tx_valid = 1'b1;
        tx_word = 16'hFFFF;
        send = 1'b1;
        repeat (200) begin
            @(negedge clk);
            if (sclk !== 1'b0 || tx_fs !== 1'b0 || txd !== 1'b0) bad++;
        end
        tx_valid = 1'b0;
        chk("ready when full", 16'h0000, {15'h0000, tx_ready});
        chk("pin activity while absent", 16'h0000, 16'(bad));
        chk("receive words while absent", 16'h0000, 16'(rx_q.size()));
    endtask
    task automatic t_clock();
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        present = 1'b1;
        repeat (8) @(negedge clk);
        while (sclk !== 1'b0) @(negedge clk);
        while (sclk !== 1'b1) @(negedge clk);
        while (sclk === 1'b1) begin
            hi++;
            @(negedge clk);
        end
        while (sclk === 1'b0) begin
            lo++;
            @(negedge clk);
        end
        chk("bit clock high cycles", 16'h0002, 16'(hi));
        chk("bit clock low cycles", 16'h0002, 16'(lo));
    endtask
    task automatic t_tx_frame();
        for (int k = 8; k < 52; k++) push(tx_pat(k));
        while (u_dspsp_dsp_model.got.size() < 52) @(negedge clk);
        for (int k = 0; k < 52; k++) begin
            chk("transmit word", tx_pat(k), u_dspsp_dsp_model.got[k]);
        end
        chk("frame sync cycles", 16'h0004, 16'(fs_len));
        chk("underruns full frame", 16'h0000, 16'(n_under));
    endtask
    task automatic t_rx_frame();
        while (rx_q.size() < 84) @(negedge clk);
        repeat (400) @(negedge clk);
        chk("receive word count", 16'h0054, 16'(rx_q.size()));
        chk("last word index", 16'h0054, 16'(n_last));
        for (int k = 0; k < 84; k++) begin
            chk("receive word", 16'hC350 + 16'(k) * 16'h0101, rx_q[k]);
        end
    endtask
    task automatic t_underrun();
        chk("no frame on empty fifo", 16'h0034, 16'(u_dspsp_dsp_model.got.size()));
        push(16'hBEEF);
        push(16'h0F0F);
        while (u_dspsp_dsp_model.got.size() < 104) @(negedge clk);
        repeat (20) @(negedge clk);
        chk("short frame word 0", 16'hBEEF, u_dspsp_dsp_model.got[52]);
        chk("short frame word 1", 16'h0F0F, u_dspsp_dsp_model.got[53]);
        for (int k = 54; k < 104; k++) begin
            chk("zero slot", 16'h0000, u_dspsp_dsp_model.got[k]);
        end
        chk("underrun pulses", 16'h0032, 16'(n_under));
    endtask
    initial begin
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        t_absent();
        t_clock();
        t_tx_frame();
        t_rx_frame();
        t_underrun();
        conclude();
    end
endmodule

/* core/dspsp_top.sv */
// DSP serial port: bit clock divider, transmit FIFO, framer and receiver
`timescale 1ns/1ps
`include "dspsp_cfg.svh"

// ============================================================
// Transmit FIFO
module dspsp_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input wire logic i_core_clk, // Core clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic i_in_valid, // Write request
    input wire logic [W-1:0] i_in_data, // Write data
    output logic o_in_ready, // Room for a word
    output logic o_out_valid, // Word available
    output logic [W-1:0] o_out_data, // Oldest word
    input wire logic i_out_ready // Pop
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic in_ready;
    } dspsp_fifo_st_t;

    dspsp_fifo_st_t f_r, f_nxt;
    logic [W-1:0] mem [D];
    logic push, pop;

    assign push = i_in_valid && f_r.in_ready;
    assign pop = i_out_ready && (f_r.cnt != '0);
    assign o_in_ready = f_r.in_ready;
    assign o_out_valid = (f_r.cnt != '0);
    assign o_out_data = mem[f_r.rp];

    always_comb begin
        f_nxt = f_r;
        if (push) begin
            f_nxt.wp = (f_r.wp == AW'(D - 1)) ? '0 : f_r.wp + 1'b1;
        end
        if (pop) begin
            f_nxt.rp = (f_r.rp == AW'(D - 1)) ? '0 : f_r.rp + 1'b1;
        end
        f_nxt.cnt = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        f_nxt.in_ready = (f_nxt.cnt != (AW+1)'(D));
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            f_r <= '{wp: '0, rp: '0, cnt: '0, in_ready: 1'b1};
        end else begin
            f_r <= f_nxt;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[f_r.wp] <= i_in_data;
        end
    end
endmodule

// ============================================================
// Serial port top
// Behaviour
// - Transmit words are 16 bits and leave most significant bit first.
// - Receive words are 16 bits, arrive most significant bit first and are assembled so.
// - The bit clock is generated here at one quarter of the video clock.
// - Bits launch after a rising bit clock edge and are sampled on the next falling edge.
// - A transmit frame opens with one bit period of high frame sync before the first bit.
// - A transmit frame holds 52 slots of 16 bits.
// - Each frame sync phase, high and low, lasts at least one bit period.
module dspsp_top (
    input wire logic i_core_clk, // Video pixel clock, 250 MHz
    input wire logic i_arst_n, // Async reset, active low
    input wire logic i_dsp_present, // Mode control: DSP attached
    input wire logic i_tx_valid, // Statistics word offered
    input wire logic [15:0] i_tx_word, // Statistics word
    output logic o_tx_ready, // FIFO has room
    output logic o_tx_underrun, // Zero slot sent, pulse
    output logic o_serial_bit_clock, // Bit clock pin
    output logic o_tx_frame_sync, // Transmit frame sync pin
    output logic o_tx_serial_data, // Transmit data pin
    input wire logic i_rx_frame_sync, // Receive frame sync pin
    input wire logic i_rx_serial_data, // Receive data pin
    output dspsp_pkg::dspsp_rx_word_t o_rx // Received bin-width word
);
    dspsp_pkg::dspsp_state_t s_r, s_nxt;
    logic fifo_valid, fifo_pop, tick;
    logic [15:0] fifo_word;

    dspsp_fifo #(.W(`DSPSP_WORD_BITS), .D(`DSPSP_FIFO_DEPTH)) u_fifo (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_in_valid(i_tx_valid),
        .i_in_data(i_tx_word),
        .o_in_ready(o_tx_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_word),
        .i_out_ready(fifo_pop)
    );

    // One tick per bit period: launch point and, for the synchronised inputs, sample point
    assign tick = (s_r.ph == `DSPSP_PH_LAUNCH);
    assign fifo_pop = tick && i_dsp_present && fifo_valid &&
        ((s_r.tx_st == dspsp_pkg::TX_SYNC) ||
         (s_r.tx_st == dspsp_pkg::TX_DATA && s_r.tx_bit == `DSPSP_BIT_LAST &&
          s_r.tx_slot != `DSPSP_TX_SLOTS - 7'h01));

    always_comb begin
        s_nxt = s_r;
        s_nxt.ph = s_r.ph + 2'h1;
        s_nxt.sclk = i_dsp_present && !s_nxt.ph[1];
        // Pin inputs pass two flops before any use
        s_nxt.rxd_s1 = i_rx_serial_data;
        s_nxt.rxd_s2 = s_r.rxd_s1;
        s_nxt.rfs_s1 = i_rx_frame_sync;
        s_nxt.rfs_s2 = s_r.rfs_s1;
        s_nxt.underrun = 1'b0;
        s_nxt.rx_valid = 1'b0;
        s_nxt.rx_last = 1'b0;
        if (!i_dsp_present) begin
            s_nxt.tx_st = dspsp_pkg::TX_IDLE;
            s_nxt.tx_fs = 1'b0;
            s_nxt.txd = 1'b0;
            s_nxt.rx_st = dspsp_pkg::RX_HUNT;
            s_nxt.rfs_prev = 1'b0;
        end else if (tick) begin
            // Launch one core cycle after the rising bit clock edge
            unique case (s_r.tx_st)
                dspsp_pkg::TX_IDLE: begin
                    s_nxt.txd = 1'b0;
                    if (fifo_valid) begin
                        s_nxt.tx_fs = 1'b1;
                        s_nxt.tx_st = dspsp_pkg::TX_SYNC;
                    end
                end
                dspsp_pkg::TX_SYNC: begin
                    s_nxt.tx_fs = 1'b0;
                    s_nxt.txd = fifo_word[15];
                    s_nxt.tx_sh = {fifo_word[14:0], 1'b0};
                    // Load tick sends bit 15 itself, so the count starts at zero
                    s_nxt.tx_bit = 4'h0;
                    s_nxt.tx_slot = 7'h00;
                    s_nxt.tx_st = dspsp_pkg::TX_DATA;
                end
                dspsp_pkg::TX_DATA: begin
                    if (s_r.tx_bit != `DSPSP_BIT_LAST) begin
                        s_nxt.txd = s_r.tx_sh[15];
                        s_nxt.tx_sh = {s_r.tx_sh[14:0], 1'b0};
                        s_nxt.tx_bit = s_r.tx_bit + 4'h1;
                    end else if (s_r.tx_slot == `DSPSP_TX_SLOTS - 7'h01) begin
                        s_nxt.txd = 1'b0;
                        s_nxt.tx_st = dspsp_pkg::TX_IDLE;
                    end else begin
                        // Starved slots go out as zero rather than stalling the frame
                        s_nxt.txd = fifo_valid ? fifo_word[15] : 1'b0;
                        s_nxt.tx_sh = fifo_valid ? {fifo_word[14:0], 1'b0} : `DSPSP_ZERO_WORD;
                        s_nxt.underrun = !fifo_valid;
                        s_nxt.tx_bit = 4'h0;
                        s_nxt.tx_slot = s_r.tx_slot + 7'h01;
                    end
                end
                default: s_nxt.tx_st = dspsp_pkg::TX_IDLE;
            endcase
            // Synchronised values hold the pins as seen one core cycle after the falling edge
            s_nxt.rfs_prev = s_r.rfs_s2;
            unique case (s_r.rx_st)
                dspsp_pkg::RX_HUNT: begin
                    if (s_r.rfs_s2 && !s_r.rfs_prev) begin
                        s_nxt.rx_st = dspsp_pkg::RX_DATA;
                        s_nxt.rx_bit = 4'h0;
                        s_nxt.rx_slot = 7'h00;
                    end
                end
                dspsp_pkg::RX_DATA: begin
                    s_nxt.rx_sh = {s_r.rx_sh[14:0], s_r.rxd_s2};
                    s_nxt.rx_bit = s_r.rx_bit + 4'h1;
                    if (s_r.rx_bit == `DSPSP_BIT_LAST) begin
                        s_nxt.rx_valid = 1'b1;
                        s_nxt.rx_data = {s_r.rx_sh[14:0], s_r.rxd_s2};
                        s_nxt.rx_slot = s_r.rx_slot + 7'h01;
                        if (s_r.rx_slot == `DSPSP_RX_SLOTS - 7'h01) begin
                            s_nxt.rx_last = 1'b1;
                            s_nxt.rx_st = dspsp_pkg::RX_HUNT;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_serial_bit_clock = s_r.sclk;
    assign o_tx_frame_sync = s_r.tx_fs;
    assign o_tx_serial_data = s_r.txd;
    assign o_tx_underrun = s_r.underrun;
    assign o_rx = '{valid: s_r.rx_valid, word: s_r.rx_data, last: s_r.rx_last};

    // ============================================================
    // Assertions
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_fs_high;
        o_tx_frame_sync [*4];
    endsequence
    sequence s_first_bit;
        !o_tx_frame_sync && s_r.tx_st == dspsp_pkg::TX_DATA;
    endsequence

    a_clk_quarter_rate: assert property ($rose(o_serial_bit_clock) |->
        o_serial_bit_clock [*2] ##1 !o_serial_bit_clock [*2])
        else $error("bit clock is not a quarter of the core clock");
    a_launch_after_rise: assert property ($changed(o_tx_serial_data) && i_dsp_present &&
        $past(i_dsp_present) |-> $past(o_serial_bit_clock) && !$past(o_serial_bit_clock, 2))
        else $error("transmit data changed away from the launch point");
    a_fs_one_period: assert property ($rose(o_tx_frame_sync) |->
        s_fs_high ##1 s_first_bit)
        else $error("frame sync not one bit period before first bit");
    a_fs_low_phase: assert property ($fell(o_tx_frame_sync) |->
        !o_tx_frame_sync [*4])
        else $error("frame sync low phase shorter than a bit period");
    a_tx_msb_first: assert property (fifo_pop |=>
        o_tx_serial_data == $past(fifo_word[15]))
        else $error("word did not start with its top bit");
    a_tx_slot_bound: assert property (s_r.tx_st == dspsp_pkg::TX_DATA |->
        s_r.tx_slot < `DSPSP_TX_SLOTS)
        else $error("transmit frame exceeds its slot count");
    a_rx_word_len: assert property (o_rx.valid |->
        $past(s_r.rx_bit, 4) == `DSPSP_BIT_LAST && $past(s_r.rx_st, 4) == dspsp_pkg::RX_DATA)
        else $error("receive word not sixteen bits");
    a_rx_last_slot: assert property (o_rx.last |-> o_rx.valid &&
        $past(s_r.rx_slot, 4) == `DSPSP_RX_SLOTS - 7'h01)
        else $error("receive frame end at wrong slot");
    a_no_dsp_idle: assert property (!i_dsp_present |=>
        !o_serial_bit_clock && !o_tx_frame_sync && !o_rx.valid &&
        s_r.rx_st == dspsp_pkg::RX_HUNT)
        else $error("port active without a DSP");
endmodule

/* inc/dspsp_cfg.svh */
// Constants of the DSP serial port
`ifndef DSPSP_CFG_SVH
`define DSPSP_CFG_SVH

// Bit period is the video clock divided by four
`define DSPSP_VIDEO_PIXEL_CLOCK_PER_BIT 4
`define DSPSP_PH_LAUNCH 2'h0
`define DSPSP_PH_LAST 2'h3
`define DSPSP_WORD_BITS 16
`define DSPSP_BIT_LAST 4'hF
`define DSPSP_TX_SLOTS 7'h34
`define DSPSP_RX_SLOTS 7'h54
`define DSPSP_FIFO_DEPTH 8
`define DSPSP_ZERO_WORD 16'h0000

`endif

/* inc/dspsp_pkg.sv */
// Types of the DSP serial port
package dspsp_pkg;

    typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_DATA} dspsp_tx_st_t;
    typedef enum logic {RX_HUNT, RX_DATA} dspsp_rx_st_t;

    typedef struct packed {
        logic [1:0] ph;
        logic sclk;
        dspsp_tx_st_t tx_st;
        logic tx_fs;
        logic txd;
        logic [15:0] tx_sh;
        logic [3:0] tx_bit;
        logic [6:0] tx_slot;
        logic underrun;
        logic rxd_s1;
        logic rxd_s2;
        logic rfs_s1;
        logic rfs_s2;
        logic rfs_prev;
        dspsp_rx_st_t rx_st;
        logic [15:0] rx_sh;
        logic [3:0] rx_bit;
        logic [6:0] rx_slot;
        logic rx_valid;
        logic [15:0] rx_data;
        logic rx_last;
    } dspsp_state_t;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
        logic last;
    } dspsp_rx_word_t;

endpackage
